// ===== query_pkg.sv
package query_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFF_LEAF_A = 8'h00;
  localparam logic [7:0] OFF_SUBLEAF_C = 8'h04;
  localparam logic [7:0] OFF_RESULT_B = 8'h08;
  localparam logic [7:0] OFF_RESULT_D = 8'h0C;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam int CTRL_GO_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;

  // ************************************************************
  // Leaf numbers and fixed values
  // ************************************************************
  localparam logic [31:0] LEAF_MAX_BASIC = 32'h0000_000F;
  localparam logic [31:0] LEAF_DESC = 32'h0000_0002;
  localparam logic [31:0] LEAF_CACHE = 32'h0000_0004;
  localparam logic [31:0] LEAF_WATCH = 32'h0000_0005;
  localparam logic [31:0] LEAF_POWER = 32'h0000_0006;
  localparam logic [31:0] LEAF_EXTFEAT = 32'h0000_0007;
  localparam logic [31:0] LEAF_DCA = 32'h0000_0009;
  localparam logic [31:0] LEAF_PERFMON = 32'h0000_000A;
  localparam logic [31:0] LEAF_TOPO = 32'h0000_000B;
  localparam logic [31:0] LEAF_XSTATE = 32'h0000_000D;
  localparam logic [31:0] LEAF_QOSMON = 32'h0000_000F;

  localparam logic [7:0] DESC_LEAD_BYTE = 8'h01;
  localparam logic [7:0] DESC_NULL = 8'h00;
  localparam logic [7:0] DESC_SHARED_SECOND_LEVEL_TRANSLATION_BUFFER_1K = 8'hC1;
  localparam logic [7:0] DESC_DATA_TRANSLATION_BUFFER_16 = 8'hC2;
  localparam logic [7:0] DESC_L3_1M = 8'hD1;
  localparam logic [7:0] DESC_L3_2M = 8'hD2;
  localparam logic [7:0] DESC_USE_LEAF4 = 8'hFF;
  localparam int DESC_INVALID_BIT = 31;

  localparam int CACHE_TYPE_NULL = 0;
  localparam int XSTATE_FIRST = 2;
  localparam int XSTATE_LAST = 62;
  localparam int QOS_FIRST_RES = 1;
  localparam int ANSWER_CYCLES = 1;

  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] d;
  } result_t;

  typedef struct packed {
    logic [31:0] leaf;
    logic [31:0] subleaf;
  } query_t;

endpackage

// ===== query_rom.sv
module query_rom
  import query_pkg::*;
#(
  parameter int NUM_CACHES = 4,
  parameter int EXT_SUBLEAF_MAX = 0,
  parameter logic [63:0] XSTATE_MASK = 64'h0000_0000_0000_0007,
  parameter logic [31:0] QOS_RES_VECTOR = 32'h0000_0002,
  parameter logic [31:0] QOS_MAX_TAG = 32'h0000_003F,
  parameter logic [7:0] PERFMON_VERSION = 8'h03
) (
  // Query
  input wire query_t q,
  // Answer
  output result_t res
);

  // ************************************************************
  // Per-index cache description (minus-one encoded)
  // ************************************************************
  function automatic result_t cache_word(input logic [31:0] idx);
    result_t r;
    r = '0;
    if (idx < 32'(NUM_CACHES)) begin
      // Type 1 data, 2 instr, 3 unified; level from index
      r.a[4:0] = (idx == 32'h1) ? 5'h2 : ((idx == 32'h0) ? 5'h1 : 5'h3);
      r.a[7:5] = (idx < 32'h2) ? 3'h1 : 3'(idx);
      // Core topology fields equal for every valid index
      r.a[31:26] = 6'h03;
      r.a[25:14] = 12'h001;
      // Ways, partitions, line size, sets: size=(w+1)(p+1)(l+1)(s+1)
      r.b[31:22] = (idx < 32'h2) ? 10'h007 : 10'h00F;
      r.b[21:12] = 10'h000;
      r.b[11:0] = 12'h03F;
      r.c = (idx < 32'h2) ? 32'h0000_003F : 32'h0000_07FF;
    end
    // Beyond last cache: type field reads zero, ends enumeration
    return r;
  endfunction

  always_comb begin
    res = '0;
    // Leaf then sub-leaf selects the answer
    case (q.leaf)
      32'h0: res.a = LEAF_MAX_BASIC;
      LEAF_DESC: begin
        // Lead byte 01H, valid bit 31 clear
        // Every code has bit 7 set, so a valid top byte must stay null
        res.a = {DESC_NULL, DESC_SHARED_SECOND_LEVEL_TRANSLATION_BUFFER_1K, DESC_DATA_TRANSLATION_BUFFER_16, DESC_LEAD_BYTE};
        // One-byte descriptors in any order
        res.b = {DESC_NULL, DESC_USE_LEAF4, DESC_L3_2M, DESC_L3_1M};
        // Unused registers reserved: bit 31 set
        res.c = 32'h8000_0000;
        res.d = 32'h8000_0000;
      end
      LEAF_CACHE: res = cache_word(q.subleaf);
      LEAF_WATCH: begin
        // Address watch and wait line sizes and extensions
        res.a = 32'h0000_0040;
        res.b = 32'h0000_0040;
        res.c = 32'h0000_0003;
        res.d = 32'h0000_1120;
      end
      LEAF_POWER: res.a = 32'h0000_0001;
      LEAF_EXTFEAT: begin
        if (q.subleaf == 32'h0) begin
          // Highest sub-leaf plus feature flags
          res.a = 32'(EXT_SUBLEAF_MAX);
          res.b = 32'h0000_0281;
        end
        // Unsupported sub-leaf returns all zero
      end
      LEAF_DCA: res.a = 32'h0000_0001;
      // Version above zero means monitoring present
      LEAF_PERFMON: res.a = {8'h07, 8'h30, 8'h04, PERFMON_VERSION};
      LEAF_TOPO: begin
        if (q.subleaf < 32'h2) begin
          res.b = (q.subleaf == 32'h0) ? 32'h0000_0001 : 32'h0000_0004;
          res.c = {16'h0, 8'(q.subleaf + 32'h1), q.subleaf[7:0]};
        end
      end
      LEAF_XSTATE: begin
        if (q.subleaf == 32'h0) begin
          // Supported-state mask across D:A and area size
          res.a = XSTATE_MASK[31:0];
          res.d = XSTATE_MASK[63:32];
          res.b = 32'h0000_0340;
          res.c = 32'h0000_0340;
        end else if (q.subleaf >= 32'(XSTATE_FIRST) && q.subleaf <= 32'(XSTATE_LAST)
                     && XSTATE_MASK[q.subleaf[5:0]]) begin
          // Size and offset of each enabled area; sub-leaf 1 reserved
          res.a = 32'h0000_0100;
          res.b = 32'h0000_0240 + ((q.subleaf - 32'h2) << 8);
        end
      end
      LEAF_QOSMON: begin
        if (q.subleaf == 32'h0) begin
          // Max tag and resource vector
          res.b = QOS_MAX_TAG;
          res.d = QOS_RES_VECTOR;
        end else if (q.subleaf < 32'h20 && q.subleaf >= 32'(QOS_FIRST_RES)
                     && QOS_RES_VECTOR[q.subleaf[4:0]]) begin
          // Set bit position is the resource sub-leaf
          res.b = 32'h0000_0001;
          res.c = QOS_MAX_TAG;
          res.d = 32'h0000_0001;
        end
      end
      default: res = '0;
    endcase
  end

endmodule

// ===== processor_info_query_unit.sv
// How it works
// - Descriptor leaf lowest A byte reads 01H
// - Valid descriptor registers hold four byte codes
// - Bit 31 set marks reserved register
// - C1H: shared TLB, 8-way, 1024 entries
// - C2H: data TLB, 4-way, 16 entries
// - D1H/D2H: 1MB/2MB third-level cache
// - FFH: use leaf 4 for caches
// - Leaf 4 enumerates until type zero
// - Cache fields encoded minus one
// - Topology data equal for all valid indices
// - Leaf 5 reports address watch features
// - Leaf 7 sub-leaf 0: max, flags
// - Leaf 7 bad sub-leaf returns zeros
// - Leaf 0AH version above zero means present
// - Leaf 0DH sub-leaf 0: mask, size
// - Leaf 0DH sub-leaves 2..62 give areas where the mask bit is set
// - Leaf 0FH sub-leaf 0: vector, max tag
// - Leaf 0FH vector bit is sub-leaf
module processor_info_query_unit
  import query_pkg::*;
#(
  parameter int NUM_CACHES = 4,
  parameter int EXT_SUBLEAF_MAX = 0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ************************************************************
  // State
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  result_t regs_r, regs_nxt;
  logic done_r, done_nxt;
  logic aw_have_r, aw_have_nxt;
  logic w_have_r, w_have_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  result_t rom_res;
  query_t rom_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic mapped(input logic [7:0] ad);
    return ad == OFF_LEAF_A || ad == OFF_SUBLEAF_C || ad == OFF_RESULT_B ||
           ad == OFF_RESULT_D || ad == OFF_CTRL || ad == OFF_STATUS;
  endfunction

  assign rom_q = '{leaf: regs_r.a, subleaf: regs_r.c};
  query_rom #(
    .NUM_CACHES(NUM_CACHES),
    .EXT_SUBLEAF_MAX(EXT_SUBLEAF_MAX)
  ) u_rom (
    .q(rom_q),
    .res(rom_res)
  );

  // ************************************************************
  // Bus and query logic
  // ************************************************************
  always_comb begin
    logic do_write;
    do_write = 1'b0;
    regs_nxt = regs_r;
    done_nxt = done_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_have_r && w_have_r && !bvalid_r) begin
      do_write = 1'b1;
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    if (do_write) begin
      case (aw_addr_r)
        OFF_LEAF_A: regs_nxt.a = merge(regs_r.a, w_data_r, w_strb_r);
        OFF_SUBLEAF_C: regs_nxt.c = merge(regs_r.c, w_data_r, w_strb_r);
        OFF_CTRL: begin
          if (w_strb_r[0] && w_data_r[CTRL_GO_BIT]) begin
            // All four result words load together
            regs_nxt = rom_res;
            done_nxt = 1'b1;
          end
        end
        default: regs_nxt = regs_r;
      endcase
      if (aw_addr_r == OFF_LEAF_A || aw_addr_r == OFF_SUBLEAF_C) begin
        done_nxt = 1'b0;
      end
    end
    awready_nxt = !aw_have_nxt;
    wready_nxt = !w_have_nxt;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFF_LEAF_A: rdata_nxt = regs_r.a;
        OFF_SUBLEAF_C: rdata_nxt = regs_r.c;
        OFF_RESULT_B: rdata_nxt = regs_r.b;
        OFF_RESULT_D: rdata_nxt = regs_r.d;
        OFF_STATUS: rdata_nxt = {30'h0, done_r, 1'b0};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regs_r <= '0;
      done_r <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= RESET_WORD;
      w_strb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= RESET_WORD;
      rresp_r <= RESP_OKAY;
    end else begin
      regs_r <= regs_nxt;
      done_r <= done_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ************************************************************
  // Checks
  // ************************************************************
  logic go_w;
  assign go_w = aw_have_r && w_have_r && !bvalid_r && aw_addr_r == OFF_CTRL && w_strb_r[0] && w_data_r[CTRL_GO_BIT];

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_load_all: assert property (@(posedge aclk) disable iff (!aresetn)
    go_w |=> regs_r == $past(rom_res)) else $error("results not loaded together");
  chk_desc_lead: assert property (@(posedge aclk) disable iff (!aresetn)
    go_w && regs_r.a == LEAF_DESC |=> regs_r.a[7:0] == DESC_LEAD_BYTE) else $error("lead byte wrong");
  chk_desc_valid: assert property (@(posedge aclk) disable iff (!aresetn)
    go_w && regs_r.a == LEAF_DESC |=> !regs_r.a[DESC_INVALID_BIT] && !regs_r.b[DESC_INVALID_BIT]
    && regs_r.d[DESC_INVALID_BIT])
    else $error("descriptor valid bit wrong");
  chk_desc_codes: assert property (@(posedge aclk) disable iff (!aresetn)
    go_w && regs_r.a == LEAF_DESC |=> regs_r.a[23:16] == DESC_SHARED_SECOND_LEVEL_TRANSLATION_BUFFER_1K && regs_r.b[23:16] == DESC_USE_LEAF4)
    else $error("descriptor codes wrong");
  chk_ext_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    go_w && regs_r.a == LEAF_EXTFEAT && regs_r.c > 32'(EXT_SUBLEAF_MAX) |=> regs_r == '0)
    else $error("leaf 7 bad sub-leaf not zero");
  chk_ext_max: assert property (@(posedge aclk) disable iff (!aresetn)
    go_w && regs_r.a == LEAF_EXTFEAT && regs_r.c == 32'h0 |=> regs_r.a == 32'(EXT_SUBLEAF_MAX))
    else $error("leaf 7 max wrong");
  chk_cache_end: assert property (@(posedge aclk) disable iff (!aresetn)
    go_w && regs_r.a == LEAF_CACHE && regs_r.c >= 32'(NUM_CACHES) |=> regs_r.a[4:0] == 5'h0)
    else $error("cache enumeration not ended");
  chk_cache_topo: assert property (@(posedge aclk) disable iff (!aresetn)
    go_w && regs_r.a == LEAF_CACHE && regs_r.c < 32'(NUM_CACHES) |=> regs_r.a[31:14] == {6'h03, 12'h001})
    else $error("topology varies");
  chk_read_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && arready_r |=> rvalid_r) else $error("read answer late");

  // Leaf contents
  chk_desc_data_translation_buffer: assert property (
    go_w && regs_r.a == LEAF_DESC |=> regs_r.a[15:8] == DESC_DATA_TRANSLATION_BUFFER_16)
    else $error("data buffer code wrong");
  chk_desc_l3: assert property (
    go_w && regs_r.a == LEAF_DESC |=> regs_r.b[15:0] == {DESC_L3_2M, DESC_L3_1M})
    else $error("third-level codes wrong");
  chk_cache_line: assert property (
    go_w && regs_r.a == LEAF_CACHE |=> $onehot({1'b0, regs_r.b[11:0]} + 13'h1))
    else $error("line size not minus one");
  chk_watch_info: assert property (
    go_w && regs_r.a == LEAF_WATCH |=> regs_r.a != 32'h0)
    else $error("watch leaf empty");
  chk_perf_version: assert property (
    go_w && regs_r.a == LEAF_PERFMON |=> regs_r.a[7:0] != 8'h00)
    else $error("monitoring version zero");
  chk_xs_mask: assert property (
    go_w && regs_r.a == LEAF_XSTATE && regs_r.c == 32'h0 |=> {regs_r.d, regs_r.a} != 64'h0 && regs_r.b != 32'h0)
    else $error("state mask or size empty");
  chk_xs_reserved: assert property (
    go_w && regs_r.a == LEAF_XSTATE && regs_r.c == 32'h1 |=> regs_r == '0)
    else $error("reserved sub-leaf not zero");
  chk_qos_base: assert property (
    go_w && regs_r.a == LEAF_QOSMON && regs_r.c == 32'h0 |=> regs_r.b != 32'h0)
    else $error("max tag zero");
  chk_qos_bit0: assert property (
    go_w && regs_r.a == LEAF_QOSMON && regs_r.c == 32'h0 |=> !regs_r.d[0])
    else $error("vector bit 0 set");
  chk_done_clear: assert property (
    aw_have_r && w_have_r && !bvalid_r && aw_addr_r == OFF_LEAF_A |=> !done_r)
    else $error("done not cleared");

  // Handshake
  chk_b_hold: assert property (
    bvalid_r && !s_axi_bready |=> bvalid_r && $stable(bresp_r))
    else $error("write response dropped");
  chk_r_hold: assert property (
    rvalid_r && !s_axi_rready |=> rvalid_r && $stable(rdata_r))
    else $error("read data dropped");
  chk_aw_refuse: assert property (
    aw_have_r |-> !awready_r) else $error("address taken while held");
  chk_w_answer: assert property (
    aw_have_r && w_have_r && !bvalid_r |=> bvalid_r)
    else $error("write answer late");

  cov_desc: cover property (@(posedge aclk) go_w && regs_r.a == LEAF_DESC);
  cov_qos: cover property (@(posedge aclk) go_w && regs_r.a == LEAF_QOSMON);
  cov_ext: cover property (@(posedge aclk) go_w && regs_r.a == LEAF_EXTFEAT);
  cov_cache: cover property (@(posedge aclk) go_w && regs_r.a == LEAF_CACHE);
  cov_xstate: cover property (@(posedge aclk) go_w && regs_r.a == LEAF_XSTATE && regs_r.c == 32'h2);

endmodule

// ===== query_sw_model.sv
module query_sw_model
  import query_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Starts one edge after entry so a release and a new request never share a time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp, output bit ok);
    ok = 1'b0;
    resp = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        resp = s_axi_bresp;
        ok = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp, output bit ok);
    ok = 1'b0;
    resp = 2'h3;
    d = 32'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        ok = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  // Topology leaf is used only when the basic range reaches it and its width field is set
  function automatic bit topo_usable(input logic [31:0] max_leaf, input logic [31:0] b);
    return (max_leaf >= LEAF_TOPO) && (b[15:0] != 16'h0000);
  endfunction
endmodule

// ===== tb_processor_info_query_unit.sv
module tb_processor_info_query_unit
  import query_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int miscompares;
  int samples_checked;

  processor_info_query_unit #(.NUM_CACHES(4), .EXT_SUBLEAF_MAX(0)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  query_sw_model sw_u (
    .aclk(aclk),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  // ************************************************************
  // Shared checks and bus access
  // ************************************************************
  task automatic report_and_stop();
    $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  task automatic bwr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] resp;
    bit ok;
    sw_u.wr(a, d, resp, ok);
    if (!ok) begin
      $display("ERROR write_wait expected %h seen %h", 1'b1, ok);
      miscompares++;
      report_and_stop();
    end
    chk("bresp", {30'h0, er}, {30'h0, resp});
  endtask

  task automatic brd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic [1:0] resp;
    bit ok;
    sw_u.rd(a, d, resp, ok);
    if (!ok) begin
      $display("ERROR read_wait expected %h seen %h", 1'b1, ok);
      miscompares++;
      report_and_stop();
    end
    chk("rresp", {30'h0, er}, {30'h0, resp});
  endtask

  task automatic query(input logic [31:0] leaf, input logic [31:0] sub, output result_t r);
    logic [31:0] st;
    bwr(OFF_LEAF_A, leaf, 2'h0);
    bwr(OFF_SUBLEAF_C, sub, 2'h0);
    bwr(OFF_CTRL, 32'h1 << CTRL_GO_BIT, 2'h0);
    brd(OFF_STATUS, st, 2'h0);
    chk("done", 32'h1 << STATUS_DONE_BIT, st);
    brd(OFF_LEAF_A, r.a, 2'h0);
    brd(OFF_RESULT_B, r.b, 2'h0);
    brd(OFF_SUBLEAF_C, r.c, 2'h0);
    brd(OFF_RESULT_D, r.d, 2'h0);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_regs();
    logic [31:0] d;
    brd(OFF_STATUS, d, 2'h0);
    chk("status_reset", RESET_WORD, d);
    bwr(8'h18, 32'hFFFF_FFFF, 2'h2);
    brd(8'h18, d, 2'h2);
    chk("unmapped", 32'h0, d);
    bwr(OFF_RESULT_B, 32'h1234_5678, 2'h0);
    brd(OFF_RESULT_B, d, 2'h0);
    chk("ro_b", RESET_WORD, d);
  endtask

  task automatic test_desc();
    result_t r;
    query(LEAF_DESC, 32'h0, r);
    chk("desc_a", {DESC_NULL, DESC_SHARED_SECOND_LEVEL_TRANSLATION_BUFFER_1K, DESC_DATA_TRANSLATION_BUFFER_16, DESC_LEAD_BYTE}, r.a);
    chk("desc_b", {DESC_NULL, DESC_USE_LEAF4, DESC_L3_2M, DESC_L3_1M}, r.b);
    chk("desc_valid", 32'h0, {31'h0, r.a[DESC_INVALID_BIT] | r.b[DESC_INVALID_BIT]});
    chk("desc_c", 32'h1 << DESC_INVALID_BIT, r.c);
    chk("desc_d", 32'h1 << DESC_INVALID_BIT, r.d);
  endtask

  task automatic test_cache();
    result_t r;
    logic [17:0] topo;
    for (int i = 0; i <= 4; i++) begin
      query(LEAF_CACHE, i, r);
      if (i == 0) topo = r.a[31:14];
      if (i < 4) begin
        chk("cache_type_set", 32'h1, {31'h0, r.a[4:0] != 5'h00});
        chk("cache_topo", {14'h0, topo}, {14'h0, r.a[31:14]});
        chk("cache_line", 32'h1, {31'h0, $onehot({1'b0, r.b[11:0]} + 13'h1)});
      end else begin
        chk("cache_type_end", 32'h0, {27'h0, r.a[4:0]});
      end
    end
  endtask

  task automatic test_ext_perf();
    result_t r;
    logic [31:0] b0, mx;
    query(LEAF_EXTFEAT, 32'h0, r);
    chk("ext_max", 32'h0, r.a);
    query(LEAF_EXTFEAT, 32'h1, r);
    chk("ext_bad", 32'h0, r.a | r.b | r.c | r.d);
    query(LEAF_PERFMON, 32'h0, r);
    chk("perf_ver", 32'h1, {31'h0, r.a[7:0] != 8'h00});
    query(32'h0, 32'h0, r);
    chk("max_leaf", LEAF_MAX_BASIC, r.a);
    mx = r.a;
    query(LEAF_WATCH, 32'h0, r);
    chk("watch_any", 32'h1, {31'h0, (r.a | r.b | r.c | r.d) != 32'h0});
    query(LEAF_TOPO, 32'h0, r);
    b0 = r.b;
    chk("topo_usable", 32'h1, {31'h0, sw_u.topo_usable(mx, b0)});
    if (sw_u.topo_usable(mx, b0)) begin
      query(LEAF_TOPO, 32'h0, r);
      chk("topo_repeat", b0, r.b);
    end
  endtask

  task automatic test_xstate_qos();
    result_t r;
    logic [63:0] mask;
    logic [31:0] vec;
    query(LEAF_XSTATE, 32'h0, r);
    mask = {r.d, r.a};
    chk("xs_mask", 32'h1, {31'h0, mask != 64'h0});
    query(LEAF_XSTATE, 32'h1, r);
    chk("xs_reserved", 32'h0, r.a | r.b | r.c | r.d);
    for (int i = XSTATE_FIRST; i <= XSTATE_LAST; i++) begin
      if (mask[i] === 1'b1) begin
        query(LEAF_XSTATE, i, r);
        chk("xs_area_size", 32'h1, {31'h0, r.a != 32'h0});
      end
    end
    query(LEAF_QOSMON, 32'h0, r);
    chk("qos_bit0", 32'h0, {31'h0, r.d[0]});
    chk("qos_tag", 32'h1, {31'h0, r.b != 32'h0});
    vec = r.d;
    for (int i = QOS_FIRST_RES; i < 32; i++) begin
      if (vec[i] === 1'b1) begin
        query(LEAF_QOSMON, i, r);
        chk("qos_res_info", 32'h1, {31'h0, r.c != 32'h0});
      end
    end
  endtask

  task automatic test_done_clear();
    logic [31:0] d;
    bwr(OFF_SUBLEAF_C, 32'h0, 2'h0);
    brd(OFF_STATUS, d, 2'h0);
    chk("done_clear", 32'h0, d);
  endtask

  // ************************************************************
  // Clock, reset and sequence
  // ************************************************************
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    $display("ERROR watchdog expected %h seen %h", 1'b0, 1'b1);
    miscompares++;
    report_and_stop();
  end

  initial begin
    aresetn = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_desc();
    test_cache();
    test_ext_perf();
    test_xstate_qos();
    test_done_clear();
    report_and_stop();
  end
endmodule
